// >>> common/jdt_pkg.sv
// Constants shared by the JTAG debug transaction port.
// Assumes a 4-bit instruction register and 32-bit transaction words.
package jdt_pkg;
  localparam int unsigned JDT_WORD_W = 32;
  localparam int unsigned JDT_CMD_W  = 4;
  // Instruction codes that select the debug data registers
  localparam logic [3:0] JDT_IR_STATUS  = 4'h8;
  localparam logic [3:0] JDT_IR_COMMAND = 4'h9;
  localparam logic [3:0] JDT_IR_ADDRESS = 4'ha;
  localparam logic [3:0] JDT_IR_DATA    = 4'hb;
  localparam logic [3:0] JDT_IR_IDCODE  = 4'hc;
  localparam logic [3:0] JDT_IR_RESET   = 4'hc;
  localparam logic [3:0] JDT_IR_CAPTURE = 4'h1;
  // Transaction command codes
  localparam logic [3:0] JDT_CMD_WR_MEM  = 4'h0;
  localparam logic [3:0] JDT_CMD_WR_CORE = 4'h1;
  localparam logic [3:0] JDT_CMD_WR_AUX  = 4'h2;
  localparam logic [3:0] JDT_CMD_NOP     = 4'h3;
  localparam logic [3:0] JDT_CMD_RD_MEM  = 4'h4;
  localparam logic [3:0] JDT_CMD_RD_CORE = 4'h5;
  localparam logic [3:0] JDT_CMD_RD_AUX  = 4'h6;
  localparam logic [3:0] JDT_CMD_OBS_WR  = 4'h7;
  localparam logic [3:0] JDT_CMD_OBS_RD  = 4'h8;
  localparam logic [3:0] JDT_CMD_RESET   = 4'h3;
  // Reset values
  localparam logic [31:0] JDT_ADDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] JDT_DATA_RESET   = 32'h0000_0000;
  localparam logic [3:0]  JDT_STATUS_RESET = 4'h0;
  // Status field positions
  localparam int unsigned JDT_STAT_STALL = 0;
  localparam int unsigned JDT_STAT_FAIL  = 1;
  localparam int unsigned JDT_STAT_READY = 2;
  localparam int unsigned JDT_STAT_PC    = 3;
  // Address handling
  localparam logic [31:0] JDT_STEP_REG = 32'h0000_0001;
  localparam logic [31:0] JDT_STEP_MEM = 32'h0000_0004;
  localparam logic [31:0] JDT_MEM_MASK = 32'hffff_fffc;
  // Address spaces on the processor-side request
  localparam logic [1:0] JDT_SPACE_MEM  = 2'h0;
  localparam logic [1:0] JDT_SPACE_CORE = 2'h1;
  localparam logic [1:0] JDT_SPACE_AUX  = 2'h2;
  // Identification word; value is arbitrary, bit 0 set as JTAG requires
  localparam logic [31:0] JDT_IDCODE = 32'h0123_4001;
endpackage

// >>> common/jdt_tap_if.sv
// State decode of the TAP controller, shared with the register logic.
// Assumes all signals are combinational decodes in the test clock domain.
`timescale 1ns/1ps
`default_nettype none
interface jdt_tap_if;
  logic tlr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  modport ctrl (output tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr);
  modport user (input tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr);
endinterface
`default_nettype wire

// >>> rtl/jdt_sync2.sv
// Two-stage level synchroniser.
// Assumes d is quasi-static or a toggle from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module jdt_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Level
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  logic meta_next;
  logic q_next;

  // First stage feeds only the second
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/jdt_tap_ctrl.sv
// TAP controller state machine with state decodes on an interface.
// Assumes tms is sampled on the rising test clock edge.
`timescale 1ns/1ps
`default_nettype none
module jdt_tap_ctrl (
  // Test clock and reset
  input  wire logic tck,
  input  wire logic trst_b,
  // Mode select pin
  input  wire logic tms,
  // State decodes
  jdt_tap_if.ctrl   tap
);
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jdt_tap_state_t;

  jdt_tap_state_t state_reg;
  jdt_tap_state_t state_next;

  // Standard walk; five high tms cycles reach TLR from anywhere
  always_comb begin
    unique case (state_reg)
      TLR:     state_next = tms ? TLR    : RTI;
      RTI:     state_next = tms ? SEL_DR : RTI;
      SEL_DR:  state_next = tms ? SEL_IR : CAP_DR;
      CAP_DR:  state_next = tms ? EX1_DR : SH_DR;
      SH_DR:   state_next = tms ? EX1_DR : SH_DR;
      EX1_DR:  state_next = tms ? UPD_DR : PAU_DR;
      PAU_DR:  state_next = tms ? EX2_DR : PAU_DR;
      EX2_DR:  state_next = tms ? UPD_DR : SH_DR;
      UPD_DR:  state_next = tms ? SEL_DR : RTI;
      SEL_IR:  state_next = tms ? TLR    : CAP_IR;
      CAP_IR:  state_next = tms ? EX1_IR : SH_IR;
      SH_IR:   state_next = tms ? EX1_IR : SH_IR;
      EX1_IR:  state_next = tms ? UPD_IR : PAU_IR;
      PAU_IR:  state_next = tms ? EX2_IR : PAU_IR;
      EX2_IR:  state_next = tms ? UPD_IR : SH_IR;
      UPD_IR:  state_next = tms ? SEL_DR : RTI;
    endcase
  end

  // Asynchronous entry to TLR on the test reset pin
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) state_reg <= TLR;
    else         state_reg <= state_next;
  end

  // Decodes used by the register logic on the next rising edge
  assign tap.tlr    = (state_reg == TLR);
  assign tap.cap_ir = (state_reg == CAP_IR);
  assign tap.sh_ir  = (state_reg == SH_IR);
  assign tap.upd_ir = (state_reg == UPD_IR);
  assign tap.cap_dr = (state_reg == CAP_DR);
  assign tap.sh_dr  = (state_reg == SH_DR);
  assign tap.upd_dr = (state_reg == UPD_DR);
endmodule
`default_nettype wire

// >>> rtl/jdt_debug_port.sv
// JTAG debug transaction port: scan registers and processor access.
// Assumes tck and clk unrelated; trst_b and rst_b asserted together
// at power-up; bus slave answers each request with one ack pulse.
//
// Overview of operation
// - Aux and memory always reachable; core registers only when halted.
// - Memory accesses ignore address bits 1:0, full word transferred.
// - Address increments after each transaction: 1 register, 4 memory.
// - Test-Logic-Reset clears the address register to zero.
// - Write completion leaves data unchanged; Test-Logic-Reset clears it.
// - Address register is 32 bits; meaning follows the command.
// - Command register is 4 bits; loading it starts a transaction.
// - Write codes: 0 memory, 1 core register, 2 aux register.
// - Read codes: 4 memory, 5 core register, 6 aux register.
// - Code 3 is no operation; 7, 8 obsolete; others reserved.
// - Instructions 8h, 9h, Ah, Bh select status, command, address, data.
// - Status is 4 bits, read only, shows completion and readiness.
// - Status bit 0 is high while the transaction is busy.
// - Status bit 1 flags failure: core access while running, bus error.
// - Status bit 2 is high once the transaction has finished.
// - Status bit 3 mirrors program counter select, no hardware effect.
// - TAP enters Test-Logic-Reset on low reset or five high tms.
`timescale 1ns/1ps
`default_nettype none
module jdt_debug_port (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // JTAG pins
  input  wire logic        tck,
  input  wire logic        trst_b,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdo_oe,
  // Processor-side access request
  output logic             dbg_req,
  output logic             dbg_write,
  output logic [1:0]       dbg_space,
  output logic [31:0]      dbg_addr,
  output logic [31:0]      dbg_wdata,
  input  wire logic        dbg_ack,
  input  wire logic        dbg_err,
  input  wire logic [31:0] dbg_rdata,
  // Processor state
  input  wire logic        cpu_halted,
  input  wire logic        program_counter_select
);
  typedef enum logic {ACC_IDLE, ACC_BUSY} jdt_acc_state_t;

  jdt_tap_if tap ();

  // Test clock domain state
  logic [3:0]  ir_sh_reg;
  logic [3:0]  ir_sh_next;
  logic [3:0]  ir_reg;
  logic [3:0]  ir_next;
  logic [31:0] dr_sh_reg;
  logic [31:0] dr_sh_next;
  logic [3:0]  cmd_reg;
  logic [3:0]  cmd_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic        launch_tgl_reg;
  logic        launch_tgl_next;
  logic        done_seen_reg;
  logic        done_seen_next;
  logic        ready_reg;
  logic        ready_next;
  logic        fail_seen_reg;
  logic        fail_seen_next;
  logic        tdo_next;
  logic        tdo_oe_next;
  logic        done_sync;
  logic        pc_sync;
  logic        done_evt;
  logic        busy;
  logic [3:0]  status_view;

  // System clock domain state
  jdt_acc_state_t acc_reg;
  jdt_acc_state_t acc_next;
  logic        launch_sync;
  logic        launch_seen_reg;
  logic        launch_seen_next;
  logic        done_tgl_reg;
  logic        done_tgl_next;
  logic        fail_reg;
  logic        fail_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        req_next;
  logic        write_next;
  logic [1:0]  space_next;
  logic [31:0] addr_out_next;
  logic [31:0] wdata_next;
  logic        launch_evt;

  // Decoded view of the held command
  logic        cmd_valid;
  logic        cmd_write;
  logic [1:0]  cmd_space;

  jdt_tap_ctrl u_tap (
    .tck    (tck),
    .trst_b (trst_b),
    .tms    (tms),
    .tap    (tap.ctrl)
  );

  // Completion toggle into the test clock domain
  jdt_sync2 u_done_sync (
    .clk   (tck),
    .rst_b (trst_b),
    .d     (done_tgl_reg),
    .q     (done_sync)
  );

  // Status bit 3 source comes from the processor clock domain
  jdt_sync2 u_pc_sync (
    .clk   (tck),
    .rst_b (trst_b),
    .d     (program_counter_select),
    .q     (pc_sync)
  );

  // Launch toggle into the system clock domain
  jdt_sync2 u_launch_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (launch_tgl_reg),
    .q     (launch_sync)
  );

  // Command decode; obsolete and reserved codes start nothing
  always_comb begin
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_space = jdt_pkg::JDT_SPACE_MEM;
    unique case (cmd_reg)
      jdt_pkg::JDT_CMD_WR_MEM: begin
        cmd_write = 1'b1;
      end
      jdt_pkg::JDT_CMD_WR_CORE: begin
        cmd_write = 1'b1;
        cmd_space = jdt_pkg::JDT_SPACE_CORE;
      end
      jdt_pkg::JDT_CMD_WR_AUX: begin
        cmd_write = 1'b1;
        cmd_space = jdt_pkg::JDT_SPACE_AUX;
      end
      jdt_pkg::JDT_CMD_RD_MEM: begin
        cmd_space = jdt_pkg::JDT_SPACE_MEM;
      end
      jdt_pkg::JDT_CMD_RD_CORE: begin
        cmd_space = jdt_pkg::JDT_SPACE_CORE;
      end
      jdt_pkg::JDT_CMD_RD_AUX: begin
        cmd_space = jdt_pkg::JDT_SPACE_AUX;
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // Busy from launch until the completion toggle is absorbed
  assign busy     = (launch_tgl_reg != done_seen_reg);
  assign done_evt = (done_sync != done_seen_reg);
  assign status_view = {pc_sync, ready_reg, fail_seen_reg, busy};

  // Instruction register; TLR reselects the identification word
  always_comb begin
    ir_sh_next = ir_sh_reg;
    ir_next    = ir_reg;
    if (tap.tlr) begin
      ir_next = jdt_pkg::JDT_IR_RESET;
    end else if (tap.cap_ir) begin
      ir_sh_next = jdt_pkg::JDT_IR_CAPTURE;
    end else if (tap.sh_ir) begin
      ir_sh_next = {tdi, ir_sh_reg[3:1]};
    end else if (tap.upd_ir) begin
      ir_next = ir_sh_reg;
    end
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      ir_sh_reg <= jdt_pkg::JDT_IR_CAPTURE;
      ir_reg    <= jdt_pkg::JDT_IR_RESET;
    end else begin
      ir_sh_reg <= ir_sh_next;
      ir_reg    <= ir_next;
    end
  end

  // Data shift path; length follows the selected register
  always_comb begin
    dr_sh_next = dr_sh_reg;
    if (tap.cap_dr) begin
      unique case (ir_reg)
        jdt_pkg::JDT_IR_STATUS:  dr_sh_next = {28'h0, status_view};
        jdt_pkg::JDT_IR_COMMAND: dr_sh_next = {28'h0, cmd_reg};
        jdt_pkg::JDT_IR_ADDRESS: dr_sh_next = addr_reg;
        jdt_pkg::JDT_IR_DATA:    dr_sh_next = data_reg;
        jdt_pkg::JDT_IR_IDCODE:  dr_sh_next = jdt_pkg::JDT_IDCODE;
        default:                 dr_sh_next = 32'h0000_0000;
      endcase
    end else if (tap.sh_dr) begin
      unique case (ir_reg)
        jdt_pkg::JDT_IR_STATUS,
        jdt_pkg::JDT_IR_COMMAND: begin
          dr_sh_next = {28'h0, tdi, dr_sh_reg[3:1]};
        end
        jdt_pkg::JDT_IR_ADDRESS,
        jdt_pkg::JDT_IR_DATA,
        jdt_pkg::JDT_IR_IDCODE: begin
          dr_sh_next = {tdi, dr_sh_reg[31:1]};
        end
        default: begin
          dr_sh_next = {31'h0, tdi}; // Unused codes act as bypass
        end
      endcase
    end
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) dr_sh_reg <= 32'h0000_0000;
    else         dr_sh_reg <= dr_sh_next;
  end

  // Transaction registers; held while busy, except for the completion update and the TLR clear, so the far side sees
  // stable words without a multi-bit synchroniser
  always_comb begin
    cmd_next        = cmd_reg;
    addr_next       = addr_reg;
    data_next       = data_reg;
    launch_tgl_next = launch_tgl_reg;
    done_seen_next  = done_sync;
    ready_next      = ready_reg;
    fail_seen_next  = fail_seen_reg;
    if (done_evt) begin
      ready_next     = 1'b1;
      fail_seen_next = fail_reg;
      if (cmd_space == jdt_pkg::JDT_SPACE_MEM) begin
        addr_next = addr_reg + jdt_pkg::JDT_STEP_MEM;
      end else begin
        addr_next = addr_reg + jdt_pkg::JDT_STEP_REG;
      end
      if (!cmd_write && !fail_reg) begin
        data_next = rdata_reg;
      end
    end
    if (tap.tlr) begin
      cmd_next       = jdt_pkg::JDT_CMD_RESET;
      addr_next      = jdt_pkg::JDT_ADDR_RESET;
      data_next      = jdt_pkg::JDT_DATA_RESET;
      ready_next     = 1'b0;
      fail_seen_next = 1'b0;
    end else if (tap.upd_dr && !busy) begin
      unique case (ir_reg)
        jdt_pkg::JDT_IR_COMMAND: begin
          cmd_next = dr_sh_reg[3:0];
          if (cmd_valid_of(dr_sh_reg[3:0])) begin
            launch_tgl_next = ~launch_tgl_reg;
            ready_next      = 1'b0;
            fail_seen_next  = 1'b0;
          end
        end
        jdt_pkg::JDT_IR_ADDRESS: addr_next = dr_sh_reg;
        jdt_pkg::JDT_IR_DATA:    data_next = dr_sh_reg;
        default:                 cmd_next  = cmd_reg;
      endcase
    end
  end

  // Only the six transaction codes launch a processor access
  function automatic logic cmd_valid_of(input logic [3:0] code);
    logic ok;
    ok = (code == jdt_pkg::JDT_CMD_WR_MEM) ||
         (code == jdt_pkg::JDT_CMD_WR_CORE) ||
         (code == jdt_pkg::JDT_CMD_WR_AUX) ||
         (code == jdt_pkg::JDT_CMD_RD_MEM) ||
         (code == jdt_pkg::JDT_CMD_RD_CORE) ||
         (code == jdt_pkg::JDT_CMD_RD_AUX);
    return ok;
  endfunction

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      cmd_reg        <= jdt_pkg::JDT_CMD_RESET;
      addr_reg       <= jdt_pkg::JDT_ADDR_RESET;
      data_reg       <= jdt_pkg::JDT_DATA_RESET;
      launch_tgl_reg <= 1'b0;
      done_seen_reg  <= 1'b0;
      ready_reg      <= 1'b0;
      fail_seen_reg  <= 1'b0;
    end else begin
      cmd_reg        <= cmd_next;
      addr_reg       <= addr_next;
      data_reg       <= data_next;
      launch_tgl_reg <= launch_tgl_next;
      done_seen_reg  <= done_seen_next;
      ready_reg      <= ready_next;
      fail_seen_reg  <= fail_seen_next;
    end
  end

  // Output stage on the falling edge gives the probe hold time
  always_comb begin
    tdo_next    = tap.sh_ir ? ir_sh_reg[0] : dr_sh_reg[0];
    tdo_oe_next = tap.sh_ir | tap.sh_dr;
  end

  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= tdo_next;
      tdo_oe <= tdo_oe_next;
    end
  end

  // Processor access engine in the system clock domain
  assign launch_evt = (launch_sync != launch_seen_reg);

  always_comb begin
    acc_next         = acc_reg;
    launch_seen_next = launch_seen_reg;
    done_tgl_next    = done_tgl_reg;
    fail_next        = fail_reg;
    rdata_next       = rdata_reg;
    req_next         = dbg_req;
    write_next       = dbg_write;
    space_next       = dbg_space;
    addr_out_next    = dbg_addr;
    wdata_next       = dbg_wdata;
    unique case (acc_reg)
      ACC_IDLE: begin
        if (launch_evt) begin
          launch_seen_next = launch_sync;
          if (cmd_space == jdt_pkg::JDT_SPACE_CORE && !cpu_halted) begin
            fail_next     = 1'b1;
            done_tgl_next = ~done_tgl_reg;
          end else begin
            fail_next  = 1'b0;
            req_next   = 1'b1;
            write_next = cmd_write;
            space_next = cmd_space;
            wdata_next = data_reg;
            if (cmd_space == jdt_pkg::JDT_SPACE_MEM) begin
              addr_out_next = addr_reg & jdt_pkg::JDT_MEM_MASK;
            end else begin
              addr_out_next = addr_reg;
            end
            acc_next = ACC_BUSY;
          end
        end
      end
      ACC_BUSY: begin
        if (dbg_ack) begin
          req_next      = 1'b0;
          fail_next     = dbg_err;
          done_tgl_next = ~done_tgl_reg;
          if (!dbg_write) begin
            rdata_next = dbg_rdata;
          end
          acc_next = ACC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg         <= ACC_IDLE;
      launch_seen_reg <= 1'b0;
      done_tgl_reg    <= 1'b0;
      fail_reg        <= 1'b0;
      rdata_reg       <= jdt_pkg::JDT_DATA_RESET;
      dbg_req         <= 1'b0;
      dbg_write       <= 1'b0;
      dbg_space       <= jdt_pkg::JDT_SPACE_MEM;
      dbg_addr        <= jdt_pkg::JDT_ADDR_RESET;
      dbg_wdata       <= jdt_pkg::JDT_DATA_RESET;
    end else begin
      acc_reg         <= acc_next;
      launch_seen_reg <= launch_seen_next;
      done_tgl_reg    <= done_tgl_next;
      fail_reg        <= fail_next;
      rdata_reg       <= rdata_next;
      dbg_req         <= req_next;
      dbg_write       <= write_next;
      dbg_space       <= space_next;
      dbg_addr        <= addr_out_next;
      dbg_wdata       <= wdata_next;
    end
  end

  // Status bit 3 is view only; nothing else reads the synced level
  // beyond the status capture above.
endmodule
`default_nettype wire

// >>> testbench/jdt_debug_port_sva.sv
// Checker for the debug port's processor-side request and pin states.
// Assumes it is bound to jdt_debug_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module jdt_debug_port_sva (
  // Clock and resets
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        trst_b,
  input wire logic        tck,
  // Pins and request
  input wire logic        tdo,
  input wire logic        tdo_oe,
  input wire logic        dbg_req,
  input wire logic        dbg_write,
  input wire logic [1:0]  dbg_space,
  input wire logic [31:0] dbg_addr,
  input wire logic [31:0] dbg_wdata,
  input wire logic        dbg_ack,
  input wire logic        cpu_halted
);
  // Request must stand whole until its ack
  addr_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req && !dbg_ack |=> dbg_req && $stable(dbg_addr))
    else $error("request address moved before ack");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req && !dbg_ack |=> $stable({dbg_write, dbg_space, dbg_wdata}))
    else $error("request kind or data moved before ack");
  // One access per launch, so a long gap follows each ack
  req_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req && dbg_ack |=> !dbg_req [*8])
    else $error("request not dropped after ack");
  req_end_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(dbg_req) |-> $past(dbg_ack))
    else $error("request ended without ack");
  mem_align_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req && dbg_space == jdt_pkg::JDT_SPACE_MEM |-> dbg_addr[1:0] == 2'h0)
    else $error("memory request not word aligned");
  space_ok_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req |-> dbg_space != 2'h3)
    else $error("request in unknown space");
  core_halt_a: assert property (@(posedge clk) disable iff (!rst_b)
    dbg_req && dbg_space == jdt_pkg::JDT_SPACE_CORE |-> cpu_halted)
    else $error("core request while running");
  tdo_reset_a: assert property (@(posedge tck)
    !trst_b |-> !tdo_oe && !tdo)
    else $error("tdo driven in test reset");
  // Main scenarios
  wr_c: cover property (@(posedge clk) dbg_req && dbg_write && dbg_ack);
  rd_c: cover property (@(posedge clk) dbg_req && !dbg_write && dbg_ack);
  core_c: cover property (@(posedge clk)
    dbg_req && dbg_space == jdt_pkg::JDT_SPACE_CORE);
endmodule
bind jdt_debug_port jdt_debug_port_sva jdt_debug_port_sva_i (.clk, .rst_b,
  .trst_b, .tck, .tdo, .tdo_oe, .dbg_req, .dbg_write, .dbg_space, .dbg_addr,
  .dbg_wdata, .dbg_ack, .cpu_halted);
`default_nettype wire

// >>> testbench/jdt_probe.sv
// JTAG debugger probe model driving the TAP pins.
// Assumes the test clock stands low between frames, 48 ns period.
`timescale 1ns/1ps
`default_nettype none
module jdt_probe (
  // TAP pins
  output logic      tck,
  output logic      trst_b,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    trst_b = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock; tdo taken just before the rise for hold margin
  task automatic cyc(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #24;
    q = tdo;
    tck = 1'b1;
    #24;
    tck = 1'b0;
  endtask
  task automatic walk(input logic [7:0] m, input int k);
    logic q;
    for (int i = 0; i < k; i++) cyc(m[i], 1'b0, q);
  endtask
  // Instruction then data, LSB first; ends in Idle, never in reset
  task automatic scan(input logic [3:0] ir, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    int   n;
    n = ir == jdt_pkg::JDT_IR_STATUS || ir == jdt_pkg::JDT_IR_COMMAND ? 4 : 32;
    dout = 32'h0;
    walk(8'h03, 4);
    for (int i = 0; i < 4; i++) cyc(i == 3, ir[i], q);
    walk(8'h01, 2);
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(8'h01, 2);
  endtask
  // Poll status until stall drops, bounded
  task automatic poll(output logic [31:0] st, output logic ok);
    ok = 1'b0;
    for (int k = 0; k < 40 && !ok; k++) begin
      scan(jdt_pkg::JDT_IR_STATUS, 32'h0, st);
      ok = st[jdt_pkg::JDT_STAT_STALL] === 1'b0;
    end
  endtask
  // Test reset held across one test clock
  task automatic pulse();
    logic q;
    trst_b = 1'b0;
    cyc(1'b1, 1'b0, q);
    trst_b = 1'b1;
    walk(8'h00, 1);
  endtask
endmodule
`default_nettype wire

// >>> testbench/jtag_debug_transaction_port_tb_top.sv
// Self-checking bench: probe on the TAP, slave model on the request side.
// Assumes the probe is the only driver of the JTAG pins.
`timescale 1ns/1ps
`default_nettype none
module jtag_debug_transaction_port_tb_top;
  localparam logic [3:0] CODES [10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6,
                                        4'h3, 4'h7, 4'h8, 4'hf};
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             dbg_ack = 1'b0;
  logic             dbg_err = 1'b0;
  logic [31:0]      dbg_rdata = 32'h0;
  logic             cpu_halted = 1'b1;
  logic             pcs = 1'b0;
  logic             err_on = 1'b0;
  logic             last_w;
  logic [1:0]       last_space;
  logic [31:0]      last_addr, last_wdata;
  wire logic        tck, trst_b, tms, tdi, tdo, tdo_oe, dbg_req, dbg_write;
  wire logic [1:0]  dbg_space;
  wire logic [31:0] dbg_addr, dbg_wdata;
  int               seed = 65752;
  int               lat = 0;
  int               n_req = 0;
  int               error_cnt = 0;
  int               n_compared = 0;
  jdt_probe jdt_probe_i (.tck, .trst_b, .tms, .tdi, .tdo);
  jdt_debug_port jdt_debug_port_i (.clk, .rst_b, .tck, .trst_b, .tms, .tdi,
    .tdo, .tdo_oe, .dbg_req, .dbg_write, .dbg_space, .dbg_addr, .dbg_wdata,
    .dbg_ack, .dbg_err, .dbg_rdata, .cpu_halted,
    .program_counter_select(pcs));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] fmem(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  // Slave: random latency; read data scrambles while idle, never stale
  always @(negedge clk) begin
    if (dbg_req && !dbg_ack && lat == 0) begin
      dbg_ack <= 1'b1;
      dbg_err <= err_on;
      dbg_rdata <= fmem(dbg_addr);
      {last_w, last_space, last_addr} <= {dbg_write, dbg_space, dbg_addr};
      last_wdata <= dbg_wdata;
      n_req <= n_req + 1;
      lat <= $random(seed) & 3;
    end else begin
      dbg_ack <= 1'b0;
      dbg_err <= 1'b0;
      dbg_rdata <= ~dbg_rdata;
      if (dbg_req && !dbg_ack) lat <= lat - 1;
    end
  end
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_done(output logic [31:0] st);
    logic ok;
    jdt_probe_i.poll(st, ok);
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH %0t stall never cleared", $time);
      print_verdict();
    end
  endtask
  task automatic chk_zero();
    logic [31:0] got;
    jdt_probe_i.scan(jdt_pkg::JDT_IR_ADDRESS, 32'h0, got);
    cmp(got, 32'h0, "address cleared");
    jdt_probe_i.scan(jdt_pkg::JDT_IR_DATA, 32'h0, got);
    cmp(got, 32'h0, "data cleared");
    cmp(tdo_oe, 1'b0, "tdo released");
  endtask
  // Full transaction, then read back status, address and data
  task automatic txn(input logic [3:0] c, input logic [31:0] a, d,
                     input logic h, input logic e);
    logic [31:0] st, got, ea, na;
    logic        live, rd, go;
    int          n0;
    @(negedge clk);
    cpu_halted = h;
    err_on = e;
    live = c < 4'h7 && c != jdt_pkg::JDT_CMD_NOP;
    rd = c[2];
    go = live && !(c[1:0] == 2'h1 && !h);
    ea = c[1:0] == 2'h0 ? a & jdt_pkg::JDT_MEM_MASK : a;
    na = c[1:0] == 2'h0 ? jdt_pkg::JDT_STEP_MEM : jdt_pkg::JDT_STEP_REG;
    na = live ? a + na : a;
    n0 = n_req;
    jdt_probe_i.scan(jdt_pkg::JDT_IR_ADDRESS, a, got);
    jdt_probe_i.scan(jdt_pkg::JDT_IR_DATA, d, got);
    jdt_probe_i.scan(jdt_pkg::JDT_IR_COMMAND, {28'h0, c}, got);
    wait_done(st);
    if (live) cmp(st, {pcs, 1'b1, !go || e, 1'b0}, "status");
    cmp(36'(n_req - n0), go, "request count");
    if (go) cmp({last_w, last_space, last_addr}, {!rd, c[1:0], ea}, "req");
    if (go && !rd) cmp(last_wdata, d, "write data");
    jdt_probe_i.scan(jdt_pkg::JDT_IR_ADDRESS, na, got);
    cmp(got, na, "address step");
    jdt_probe_i.scan(jdt_pkg::JDT_IR_DATA, d, got);
    cmp(got, go && rd && !e ? fmem(ea) : d, "data");
  endtask
  initial begin
    logic [31:0] got;
    #450000;
    error_cnt++;
    $display("MISMATCH %0t run did not finish", $time);
    print_verdict();
  end
  initial begin
    logic [31:0] got;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    jdt_probe_i.pulse();
    chk_zero();
    jdt_probe_i.scan(jdt_pkg::JDT_IR_STATUS, 32'h0, got);
    cmp(got, 32'h0, "status reset");
    pcs = 1'b1;
    for (int k = 0; k < 12; k++)
      txn(CODES[k % 6], $random(seed), $random(seed), k % 4 != 1, k % 5 == 4);
    for (int k = 6; k < 10; k++)
      txn(CODES[k], $random(seed), $random(seed), 1'b1, 1'b0);
    // Byte update: whole word read, then written back with one byte new
    txn(4'h4, 32'h200, 32'h0, 1'b1, 1'b0);
    txn(4'h0, 32'h200, fmem(32'h200) & ~32'hff | 32'h5a, 1'b1, 1'b0);
    // Two writes from one load: address steps, data reused
    jdt_probe_i.scan(jdt_pkg::JDT_IR_ADDRESS, 32'h0000_0102, got);
    jdt_probe_i.scan(jdt_pkg::JDT_IR_DATA, 32'hc0de_5a17, got);
    for (int k = 0; k < 2; k++) begin
      jdt_probe_i.scan(jdt_pkg::JDT_IR_COMMAND, 32'h0, got);
      wait_done(got);
    end
    cmp(last_addr, 32'h0000_0104, "second write address");
    cmp(last_wdata, 32'hc0de_5a17, "second write data");
    jdt_probe_i.pulse();
    chk_zero();
    jdt_probe_i.scan(jdt_pkg::JDT_IR_ADDRESS, 32'h0000_0040, got);
    jdt_probe_i.walk(8'h1f, 6);
    chk_zero();
    print_verdict();
  end
endmodule
`default_nettype wire
